// *** col_turnaround_cfg.svh ***
// Constants for the column read/write turnaround scheduler.
`ifndef COL_TURNAROUND_CFG_SVH
`define COL_TURNAROUND_CFG_SVH

// ----------------------------------------------------------------------------
// Clocks
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define REQ_CLK_PERIOD_NS 40
`define REQ_DIV (`REQ_CLK_PERIOD_NS / `CLK_PERIOD_NS)
`define REQ_DIV_W 4
`define REQ_HALF 4'h2
`define REQ_LAST 4'h3

// ----------------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------------
`define DATA_W 16
`define REQ_W 12
`define ADDR_W 9
`define DEV_NUM 2
`define DEV_W 1
`define CNT_W 8
`define DLY_W 5
`define PIPE_DEPTH 32
`define FIFO_DEPTH 16

// ----------------------------------------------------------------------------
// Request packet fields
// ----------------------------------------------------------------------------
`define PKT_COL_BIT 11
`define PKT_WR_BIT 10
`define PKT_DEV_BIT 9
`define PKT_ADDR_LSB 0

// ----------------------------------------------------------------------------
// Reset and saturation values
// ----------------------------------------------------------------------------
`define SINCE_RST 8'hff
`define SINCE_MAX 8'hff

`endif

// *** col_turnaround_pkg.sv ***
// Types for the column read/write turnaround scheduler.
package col_turnaround_pkg;

  // ----------------------------------------------------------------------------
  // Type of the most recent column command
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    col_none = 3'b001,
    col_rd = 3'b010,
    col_wr = 3'b100
  } col_type_e;

endpackage

// *** fifo_buf.sv ***
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module fifo_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!resetn)
    count_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");

endmodule // fifo_buf

// *** col_turnaround_ctrl.sv ***
// Controller that schedules column commands and their data around turnarounds.
// Overview of operation
// - Write data leaves the write data delay plus request flight minus write data flight after its column write.
// - After a write, wait the write-to-read turnaround before any read.
// - Write-to-read spacing holds for any bank, same or different.
// - Write-to-read data gap follows from turnaround, read and write delays.
// - After a read, wait the read-to-write turnaround before any write.
// - Read-to-write spacing holds for any bank, same or different.
// - Read-to-write turnaround at least read minus write delay, plus cycle, bubble.
// - Equal request and data flight lets write data use the plain delay.
// - Unequal flight delays shift the write data launch to compensate.
// - Read data expected after read delay plus both flight delays.
// - Request flight delay and read latency are tracked per device.
// - Extra round-trip data flight adds to turnaround and bubble alike.
// - Device bubble equals controller bubble plus both data flight delays.
// - Column commands are spaced at least one column cycle apart.
`timescale 1ns/1ps
`include "col_turnaround_cfg.svh"
module col_turnaround_ctrl import col_turnaround_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`CNT_W-1:0] cfg_col_cycle,
  input wire logic [`CNT_W-1:0] cfg_write_delay,
  input wire logic [`CNT_W-1:0] cfg_read_delay,
  input wire logic [`CNT_W-1:0] cfg_write_read_turn,
  input wire logic [`CNT_W-1:0] cfg_read_write_turn,
  input wire logic [`CNT_W-1:0] cfg_read_write_bubble,
  input wire logic [`DEV_NUM*`DLY_W-1:0] request_flight_delay,
  input wire logic [`DLY_W-1:0] write_data_flight_delay,
  input wire logic [`DLY_W-1:0] read_data_flight_delay,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [`DEV_W-1:0] cmd_dev,
  input wire logic [`ADDR_W-1:0] cmd_addr,
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [`DATA_W-1:0] wdata,
  output logic rdata_valid,
  output logic [`DATA_W-1:0] rdata,
  output logic [`REQ_W-1:0] request_pins,
  output logic request_clock_pair_p,
  output logic request_clock_pair_n,
  output logic [`DATA_W-1:0] data_pin_pairs_o,
  output logic [`DATA_W-1:0] data_pin_pairs_oe,
  input wire logic [`DATA_W-1:0] data_pin_pairs_i
);

  // ----------------------------------------------------------------------------
  // Request clock divider
  // ----------------------------------------------------------------------------
  logic [`REQ_DIV_W-1:0] div_ff;
  logic tick;
  logic clk_p_ff;
  logic clk_n_ff;

  assign tick = (div_ff == `REQ_LAST);
  assign request_clock_pair_p = clk_p_ff;
  assign request_clock_pair_n = clk_n_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= '0;
    end else if (tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_p_ff <= 1'b0;
      clk_n_ff <= 1'b1;
    end else begin
      clk_p_ff <= (div_ff == `REQ_LAST) || (div_ff < `REQ_HALF - 1'b1);
      clk_n_ff <= !((div_ff == `REQ_LAST) || (div_ff < `REQ_HALF - 1'b1));
    end
  end

  // ----------------------------------------------------------------------------
  // Write data buffer
  // ----------------------------------------------------------------------------
  logic wf_valid;
  logic wf_pop;
  logic [`DATA_W-1:0] wf_data;

  fifo_buf #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_wfifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data(wdata),
    .out_valid(wf_valid),
    .out_ready(wf_pop),
    .out_data(wf_data)
  );

  // ----------------------------------------------------------------------------
  // Per-device delays
  // ----------------------------------------------------------------------------
  logic [`DLY_W-1:0] rq_flight;
  logic [9:0] wr_dly_raw;
  logic [9:0] rd_dly_raw;
  logic [9:0] drw_sum;
  logic [9:0] drw_min;
  logic [`DLY_W-1:0] wr_dly;
  logic [`DLY_W-1:0] rd_dly;
  logic [`CNT_W-1:0] drw_eff;

  assign rq_flight = request_flight_delay[cmd_dev*`DLY_W +: `DLY_W];
  assign wr_dly_raw = 10'(cfg_write_delay) + 10'(rq_flight) - 10'(write_data_flight_delay);
  assign rd_dly_raw = 10'(cfg_read_delay) + 10'(rq_flight) + 10'(read_data_flight_delay);
  assign drw_sum = 10'(cfg_read_delay) + 10'(cfg_col_cycle) + 10'(cfg_read_write_bubble)
                 + 10'(write_data_flight_delay) + 10'(read_data_flight_delay);
  assign drw_min = (drw_sum > 10'(cfg_write_delay)) ? drw_sum - 10'(cfg_write_delay) : 10'h000;

  always_comb begin
    wr_dly = `DLY_W'(wr_dly_raw);
    if (wr_dly_raw[9] || wr_dly_raw == 10'h000) begin
      wr_dly = `DLY_W'(1);
    end else if (wr_dly_raw > 10'(`PIPE_DEPTH)) begin
      wr_dly = `DLY_W'(`PIPE_DEPTH - 1);
    end
    rd_dly = `DLY_W'(rd_dly_raw);
    if (rd_dly_raw == 10'h000) begin
      rd_dly = `DLY_W'(1);
    end else if (rd_dly_raw > 10'(`PIPE_DEPTH)) begin
      rd_dly = `DLY_W'(`PIPE_DEPTH - 1);
    end
    drw_eff = cfg_read_write_turn;
    if (drw_min > 10'(cfg_read_write_turn)) begin
      drw_eff = (drw_min > 10'(`SINCE_MAX)) ? `SINCE_MAX : `CNT_W'(drw_min);
    end
  end

  // ----------------------------------------------------------------------------
  // Column command scheduler
  // ----------------------------------------------------------------------------
  col_type_e last_ff;
  logic [`CNT_W-1:0] since_ff;
  logic cc_ok;
  logic turn_ok;
  logic data_ok;
  logic issue;

  assign cc_ok = (since_ff >= cfg_col_cycle);
  always_comb begin
    turn_ok = 1'b1;
    if (cmd_write && last_ff == col_rd) begin
      turn_ok = (since_ff >= drw_eff);
    end else if (!cmd_write && last_ff == col_wr) begin
      turn_ok = (since_ff >= cfg_write_read_turn);
    end
  end
  assign data_ok = !cmd_write || wf_valid;
  assign cmd_ready = tick && cc_ok && turn_ok && data_ok;
  assign issue = cmd_valid && cmd_ready;
  assign wf_pop = issue && cmd_write;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_ff <= col_none;
    end else if (issue) begin
      case (cmd_write)
        1'b1: last_ff <= col_wr;
        1'b0: last_ff <= col_rd;
        default: last_ff <= col_none;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      since_ff <= `SINCE_RST;
    end else if (issue) begin
      since_ff <= `CNT_W'(1);
    end else if (tick && since_ff != `SINCE_MAX) begin
      since_ff <= since_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Request packet
  // ----------------------------------------------------------------------------
  logic [`REQ_W-1:0] req_ff;
  assign request_pins = req_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ff <= '0;
    end else if (issue) begin
      req_ff <= '0;
      req_ff[`PKT_COL_BIT] <= 1'b1;
      req_ff[`PKT_WR_BIT] <= cmd_write;
      req_ff[`PKT_DEV_BIT] <= cmd_dev;
      req_ff[`PKT_ADDR_LSB +: `ADDR_W] <= cmd_addr;
    end else if (tick) begin
      req_ff <= '0;
    end
  end

  // ----------------------------------------------------------------------------
  // Launch and capture delay lines
  // ----------------------------------------------------------------------------
  logic [`PIPE_DEPTH-1:0] wr_pipe_ff;
  logic [`PIPE_DEPTH-1:0] rd_pipe_ff;
  logic [`DATA_W-1:0] dat_pipe_ff [`PIPE_DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < `PIPE_DEPTH; gi++) begin : g_pipe
      logic wr_up;
      logic rd_up;
      logic [`DATA_W-1:0] dat_up;
      if (gi == `PIPE_DEPTH - 1) begin : g_top
        assign wr_up = 1'b0;
        assign rd_up = 1'b0;
        assign dat_up = '0;
      end else begin : g_mid
        assign wr_up = wr_pipe_ff[gi+1];
        assign rd_up = rd_pipe_ff[gi+1];
        assign dat_up = dat_pipe_ff[gi+1];
      end
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          wr_pipe_ff[gi] <= 1'b0;
          rd_pipe_ff[gi] <= 1'b0;
          dat_pipe_ff[gi] <= '0;
        end else if (tick) begin
          wr_pipe_ff[gi] <= wr_up || (wf_pop && wr_dly == `DLY_W'(gi + 1));
          rd_pipe_ff[gi] <= rd_up || (issue && !cmd_write && rd_dly == `DLY_W'(gi + 1));
          dat_pipe_ff[gi] <= (wf_pop && wr_dly == `DLY_W'(gi + 1)) ? wf_data : dat_up;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------------------------------
  logic [`DATA_W-1:0] dq_o_ff;
  logic dq_oe_ff;
  logic [`CNT_W-1:0] drive_ff;

  assign data_pin_pairs_o = dq_o_ff;
  assign data_pin_pairs_oe = {`DATA_W{dq_oe_ff}};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
      drive_ff <= '0;
    end else if (tick && wr_pipe_ff[0]) begin
      dq_o_ff <= dat_pipe_ff[0];
      dq_oe_ff <= 1'b1;
      drive_ff <= cfg_col_cycle;
    end else if (tick && drive_ff > `CNT_W'(1)) begin
      drive_ff <= drive_ff - 1'b1;
    end else if (tick) begin
      dq_oe_ff <= 1'b0;
      drive_ff <= '0;
    end
  end

  // ----------------------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------------------
  logic [`DATA_W-1:0] dq_s1_ff;
  logic [`DATA_W-1:0] dq_s2_ff;
  logic rvalid_ff;
  logic [`DATA_W-1:0] rdata_ff;

  assign rdata_valid = rvalid_ff;
  assign rdata = rdata_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else begin
      dq_s1_ff <= data_pin_pairs_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      rvalid_ff <= tick && rd_pipe_ff[0];
      if (tick && rd_pipe_ff[0]) begin
        rdata_ff <= dq_s2_ff;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wr_issue;
    issue && cmd_write;
  endsequence

  sequence s_rd_issue;
    issue && !cmd_write;
  endsequence

  col_spacing_a: assert property (issue |=> !issue [*3])
    else $error("column commands closer than one request cycle");
  rd_after_wr_a: assert property (s_rd_issue and (last_ff == col_wr) |->
    since_ff >= cfg_write_read_turn)
    else $error("read issued inside write-to-read turnaround");
  wr_after_rd_a: assert property (s_wr_issue and (last_ff == col_rd) |->
    since_ff >= drw_eff && 10'(since_ff) >= drw_min)
    else $error("write issued inside read-to-write turnaround");
  last_type_a: assert property (s_wr_issue |=> last_ff == col_wr && since_ff == `CNT_W'(1))
    else $error("last command type not recorded");
  req_pkt_a: assert property (issue |=> request_pins[`PKT_COL_BIT] [*4] ##1
    !request_pins[`PKT_COL_BIT] || $past(issue))
    else $error("request packet not held one request cycle");
  wr_launch_a: assert property ($rose(dq_oe_ff) |-> $past(wr_pipe_ff[0] && tick))
    else $error("write data driven without scheduled launch");
  rd_capture_a: assert property (rdata_valid |-> $past(rd_pipe_ff[0]) && !$past(rdata_valid))
    else $error("read data captured off schedule");
  clk_pair_a: assert property (request_clock_pair_p != request_clock_pair_n)
    else $error("request clock pair not complementary");
  pop_fifo_a: assert property (s_wr_issue |-> wf_valid)
    else $error("write issued without buffered data");

endmodule // col_turnaround_ctrl

// *** dram_col_model.sv ***
// Behavioural model of the memory device as seen across the request and data pins.
`timescale 1ns/1ps
`include "col_turnaround_cfg.svh"
module dram_col_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`CNT_W-1:0] cfg_col_cycle,
  input wire logic [`CNT_W-1:0] cfg_write_delay,
  input wire logic [`CNT_W-1:0] cfg_read_delay,
  input wire logic [`DEV_NUM*`DLY_W-1:0] request_flight_delay,
  input wire logic [`DLY_W-1:0] write_data_flight_delay,
  input wire logic [`DLY_W-1:0] read_data_flight_delay,
  input wire logic [`REQ_W-1:0] request_pins,
  input wire logic [`DATA_W-1:0] data_pin_pairs_o,
  input wire logic [`DATA_W-1:0] data_pin_pairs_oe,
  output logic [`DATA_W-1:0] data_pin_pairs_i,
  output int wr_count,
  output int wr_lat,
  output int oe_len,
  output logic [`DATA_W:0] wr_log [0:31]
);
  // ----------------------------------------------------------------------------
  // Column command decode and data timing
  // ----------------------------------------------------------------------------
  logic [`DATA_W-1:0] dev_drv;
  logic [`REQ_W-1:0] last_pkt;
  logic oe_prev;
  int cyc_m;
  int wr_seen;
  int oe_cnt;
  int drv_end;
  int fl;
  int rd_due[$];
  int wr_due[$];
  logic [`DATA_W-1:0] rd_val[$];

  // The wire carries the controller's value while it drives, else the device's.
  assign data_pin_pairs_i = data_pin_pairs_oe[0] ? data_pin_pairs_o : dev_drv;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_m = 0;
      wr_count = 0;
      wr_lat = 0;
      oe_len = 0;
      oe_cnt = 0;
      drv_end = 0;
      wr_seen = 0;
      oe_prev = 1'b0;
      last_pkt = '0;
      rd_due.delete();
      wr_due.delete();
      rd_val.delete();
      dev_drv <= 16'h0000;
      for (int i = 0; i < 32; i++) begin
        wr_log[i] = '0;
      end
    end else begin
      cyc_m = cyc_m + 1;
      if (request_pins[11] && request_pins !== last_pkt) begin
        fl = request_pins[9] ? int'(request_flight_delay[9:5]) : int'(request_flight_delay[4:0]);
        if (request_pins[10]) begin
          wr_seen = cyc_m;
          wr_due.push_back(cyc_m + 4 * (int'(cfg_write_delay) + fl
                                        - int'(write_data_flight_delay)));
        end else begin
          rd_due.push_back(cyc_m + 4 * (int'(cfg_read_delay) + fl
                                        + int'(read_data_flight_delay)) - 4);
          rd_val.push_back({7'h00, request_pins[8:0]} ^ 16'h5a3c);
        end
      end
      last_pkt = request_pins;
      if (rd_due.size() > 0 && rd_due[0] == cyc_m) begin
        dev_drv <= rd_val[0];
        drv_end = cyc_m + 4 * int'(cfg_col_cycle);
        void'(rd_due.pop_front());
        void'(rd_val.pop_front());
      end else if (cyc_m >= drv_end) begin
        dev_drv <= ~dev_drv;
      end
      if (wr_due.size() > 0 && wr_due[0] == cyc_m) begin
        wr_log[wr_count] = {data_pin_pairs_oe[0], data_pin_pairs_o};
        wr_count = wr_count + 1;
        void'(wr_due.pop_front());
      end
      if (data_pin_pairs_oe[0] && !oe_prev) begin
        wr_lat = cyc_m - wr_seen;
      end
      if (data_pin_pairs_oe[0]) begin
        oe_cnt = oe_cnt + 1;
      end else if (oe_prev) begin
        oe_len = oe_cnt;
        oe_cnt = 0;
      end
      oe_prev = data_pin_pairs_oe[0];
    end
  end
endmodule // dram_col_model

// *** column_rw_turnaround_timing_tb.sv ***
// Self-checking testbench for the column turnaround controller.
`timescale 1ns/1ps
`include "col_turnaround_cfg.svh"
module column_rw_turnaround_timing_tb;
  // ----------------------------------------------------------------------------
  // Settings, signals and instances
  // ----------------------------------------------------------------------------
  localparam int CC = 2, WD = 3, RD = 5, WRT = 6, RWT = 2, BUB = 1, WF = 1, RF = 1;
  localparam int RQF0 = 0, RQF1 = 1;
  logic clk, resetn, cmd_valid, cmd_write, wdata_valid;
  logic [`DEV_W-1:0] cmd_dev;
  logic [`ADDR_W-1:0] cmd_addr;
  logic [`DATA_W-1:0] wdata;
  logic [`CNT_W-1:0] cfg_cc, cfg_wd, cfg_rd, cfg_wrt, cfg_rwt, cfg_bub;
  logic [`DEV_NUM*`DLY_W-1:0] rqf;
  logic [`DLY_W-1:0] wf, rf;
  logic cmd_ready, wdata_ready, rdata_valid, clk_p, clk_n;
  logic [`DATA_W-1:0] rdata, pin_o, pin_oe, pin_i;
  logic [`REQ_W-1:0] req;
  logic [`DATA_W:0] wr_log [0:31];
  int wr_count, wr_lat, oe_len;
  int failures = 0;
  int checks = 0;
  int cyc = 0;

  col_turnaround_ctrl DUT (.clk(clk), .resetn(resetn), .cfg_col_cycle(cfg_cc),
    .cfg_write_delay(cfg_wd), .cfg_read_delay(cfg_rd), .cfg_write_read_turn(cfg_wrt),
    .cfg_read_write_turn(cfg_rwt), .cfg_read_write_bubble(cfg_bub),
    .request_flight_delay(rqf), .write_data_flight_delay(wf), .read_data_flight_delay(rf),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_dev(cmd_dev),
    .cmd_addr(cmd_addr), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready),
    .wdata(wdata), .rdata_valid(rdata_valid), .rdata(rdata), .request_pins(req),
    .request_clock_pair_p(clk_p), .request_clock_pair_n(clk_n), .data_pin_pairs_o(pin_o),
    .data_pin_pairs_oe(pin_oe), .data_pin_pairs_i(pin_i));

  dram_col_model model (.clk(clk), .resetn(resetn), .cfg_col_cycle(cfg_cc),
    .cfg_write_delay(cfg_wd), .cfg_read_delay(cfg_rd), .request_flight_delay(rqf),
    .write_data_flight_delay(wf), .read_data_flight_delay(rf), .request_pins(req),
    .data_pin_pairs_o(pin_o), .data_pin_pairs_oe(pin_oe), .data_pin_pairs_i(pin_i),
    .wr_count(wr_count), .wr_lat(wr_lat), .oe_len(oe_len), .wr_log(wr_log));

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic give_up(input string msg);
    failures++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    stop_test();
  endtask

  task automatic issue(input logic wr, input logic [`DEV_W-1:0] dev,
                       input logic [`ADDR_W-1:0] addr, output int t);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_dev <= dev;
    cmd_addr <= addr;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    if (n == 400) give_up("command");
    t = cyc;
    cmd_valid <= 1'b0;
    #1;
    check(32'(req), 32'({1'b1, wr, dev, addr}), "request packet");
  endtask

  task automatic push(input logic [`DATA_W-1:0] d);
    int n;
    @(posedge clk);
    wdata_valid <= 1'b1;
    wdata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wdata_ready === 1'b1) break;
    end
    if (n == 50) give_up("push");
    wdata_valid <= 1'b0;
  endtask

  task automatic wait_read(input int t, input int lat, input logic [`ADDR_W-1:0] addr);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (rdata_valid === 1'b1) break;
    end
    if (n == 400) give_up("read data");
    check(32'(cyc - t), 32'(4 * lat + 1), "read latency");
    check(32'(rdata), 32'({7'h00, addr} ^ 16'h5a3c), "read data");
  endtask

  task automatic wait_writes(input int want);
    int n;
    for (n = 0; n < 400 && wr_count < want; n++) begin
      @(posedge clk);
    end
    if (n == 400) give_up("write data");
    #1;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reads();
    int t1, t2;
    int hi;
    hi = 0;
    issue(1'b0, 1'b0, 9'h011, t1);
    issue(1'b0, 1'b1, 9'h022, t2);
    check(32'(t2 - t1), 32'(4 * CC), "read to read spacing");
    wait_read(t1, RD + RQF0 + RF, 9'h011);
    wait_read(t2, RD + RQF1 + RF, 9'h022);
    repeat (4) begin
      @(posedge clk);
      hi = hi + int'(clk_p);
      check(32'(clk_n), 32'(!clk_p), "request clock pair");
    end
    check(32'(hi), 32'h2, "request clock duty");
    $display("test reads done");
  endtask

  task automatic t_fill_drain();
    int t[16];
    int base;
    int seen;
    base = wr_count;
    seen = 0;
    for (int i = 0; i < 16; i++) push(16'h1000 + 16'(i));
    @(posedge clk);
    wdata_valid <= 1'b1;
    wdata <= 16'hdead;
    repeat (4) @(posedge clk);
    check(32'(wdata_ready), 32'h0, "buffer full");
    wdata_valid <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      issue(1'b1, 1'b1, 9'h100 + 9'(i), t[i]);
      if (i > 0) check(32'(t[i] - t[i-1]), 32'(4 * CC), "write spacing");
    end
    wait_writes(base + 16);
    for (int i = 0; i < 16; i++) begin
      check(32'(wr_log[base+i]), 32'({1'b1, 16'h1000 + 16'(i)}), "write data");
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_dev <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) seen = 1;
    end
    check(32'(seen), 32'h0, "write without data refused");
    cmd_valid <= 1'b0;
    $display("test fill and drain done");
  endtask

  task automatic t_write_skew();
    int t;
    push(16'hbeef);
    issue(1'b1, 1'b0, 9'h033, t);
    wait_writes(wr_count + 1);
    check(32'(wr_log[wr_count-1]), 32'({1'b1, 16'hbeef}), "skewed write data");
    check(32'(wr_lat), 32'(4 * (WD + RQF0 - WF)), "skewed write launch");
    repeat (4 * CC + 2) @(posedge clk);
    check(32'(oe_len), 32'(4 * CC), "write packet length");
    $display("test write skew done");
  endtask

  task automatic t_wr_rd();
    int tw, tr;
    push(16'h7777);
    issue(1'b1, 1'b1, 9'h044, tw);
    issue(1'b0, 1'b0, 9'h055, tr);
    check(32'(tr - tw), 32'(4 * WRT), "write to read spacing");
    wait_read(tr, RD + RQF0 + RF, 9'h055);
    check(32'(wr_log[wr_count-1]), 32'({1'b1, 16'h7777}), "write before read");
    $display("test write then read done");
  endtask

  task automatic t_rd_wr();
    int tw, tr, n;
    n = wr_count;
    push(16'h8888);
    issue(1'b0, 1'b1, 9'h066, tr);
    issue(1'b1, 1'b1, 9'h077, tw);
    check(32'(tw - tr), 32'(4 * (RD + CC + BUB + WF + RF - WD)), "read to write");
    wait_read(tr, RD + RQF1 + RF, 9'h066);
    wait_writes(n + 1);
    check(32'(wr_log[n]), 32'({1'b1, 16'h8888}), "write after read");
    $display("test read then write done");
  endtask

  // ----------------------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_dev = '0;
    cmd_addr = '0;
    wdata_valid = 1'b0;
    wdata = '0;
    cfg_cc = 8'(CC);
    cfg_wd = 8'(WD);
    cfg_rd = 8'(RD);
    cfg_wrt = 8'(WRT);
    cfg_rwt = 8'(RWT);
    cfg_bub = 8'(BUB);
    rqf = {5'(RQF1), 5'(RQF0)};
    wf = 5'(WF);
    rf = 5'(RF);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reads();
    t_fill_drain();
    t_write_skew();
    t_wr_rd();
    t_rd_wr();
    stop_test();
  end
endmodule // column_rw_turnaround_timing_tb
